// *** psim_map.sv ***
// Port status bit map and read-only word input map
// Functional notes
// - Even-position bit follows signal line short
// - Short detect only in standard output mode
// - Supply trip sticky, supply off until reset
// - Low-supply bit follows 18V comparator
// - Deep-undervoltage bit follows 11V comparator
// - Mode bit one only while running IO-Link
// - Device event sets port event bit
// - Clear request or event readout clears bit
// - Data-valid bit needs valid data and IO-Link
// - Enabled validation sets bit on identity mismatch
// - Cleared when disabled, matching or leaving IO-Link
// - Word map has no write path
// - Error code latched at error, then held
// - Warning code follows warning flag
// - Areas packed in port order from word four
// - Area size is bytes halved, rounded up
// - Byte lengths set sizes and starting words
// - C/Q and aux lines idle until port mode configured; supply off in reset, enabled from first edge after release unless tripped
// - Word map read as 16-bit words
// - Warning flag on minor fault, ready kept
// - Major fault drops ready, error flag sticks
module psim_map
  import psim_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_cfg_wr,
  input  wire logic [2:0]              i_cfg_port,
  input  wire logic [1:0]              i_cfg_mode,
  input  wire logic [PSIM_LEN_W-1:0]   i_cfg_len,
  input  wire logic                    i_cfg_val_en,
  input  wire logic [PSIM_PORTS-1:0]   i_cq_short,
  input  wire logic [PSIM_PORTS-1:0]   i_supply_trip,
  input  wire logic [PSIM_PORTS-1:0]   i_cq_level,
  input  wire logic [PSIM_PORTS-1:0]   i_aux_level,
  input  wire logic                    i_supply_le_18v,
  input  wire logic                    i_supply_le_11v,
  input  wire logic [PSIM_PORTS-1:0]   i_iolink_active,
  input  wire logic [PSIM_PORTS-1:0]   i_dev_event,
  input  wire logic [PSIM_PORTS-1:0]   i_event_read,
  input  wire logic [PSIM_PORTS-1:0]   i_pd_valid,
  input  wire logic [PSIM_PORTS-1:0]   i_id_mismatch,
  input  wire logic                    i_pd_wr,
  input  wire logic [2:0]              i_pd_port,
  input  wire logic [PSIM_IDX_W-1:0]   i_pd_index,
  input  wire logic [PSIM_WORD_W-1:0]  i_pd_data,
  input  wire logic                    i_link_up,
  input  wire logic                    i_major_fault,
  input  wire logic [PSIM_WORD_W-1:0]  i_fault_code,
  input  wire logic                    i_minor_fault,
  input  wire logic [PSIM_WORD_W-1:0]  i_warn_code,
  input  wire logic [PSIM_PORTS-1:0]   i_event_clear_req,
  input  wire logic [PSIM_ADDR_W-1:0]  i_word_addr,
  output logic      [PSIM_RX_BITS-1:0] o_remote_bit_inputs,
  output logic      [PSIM_WORD_W-1:0]  o_remote_word_inputs,
  output logic      [PSIM_ADDR_W-1:0]  o_map_words,
  output logic      [PSIM_PORTS-1:0]   o_cq_enable,
  output logic      [PSIM_PORTS-1:0]   o_aux_enable,
  output logic      [PSIM_PORTS-1:0]   o_supply_en
);

  localparam int SYNC_W = 4 * PSIM_PORTS + 2;

  psim_layout_if lay ();

  logic [SYNC_W-1:0]      sync_a;
  logic [SYNC_W-1:0]      sync_b;
  logic [PSIM_PORTS-1:0]  short_s;
  logic [PSIM_PORTS-1:0]  trip_s;
  logic [PSIM_PORTS-1:0]  cq_s;
  logic [PSIM_PORTS-1:0]  aux_s;
  logic                   le18_s;
  logic                   le11_s;

  psim_mode_t             port_mode [PSIM_PORTS];
  logic [PSIM_LEN_W-1:0]  port_len  [PSIM_PORTS];
  logic [PSIM_PORTS-1:0]  val_en;
  logic [PSIM_PORTS-1:0]  supply_tripped;
  logic [PSIM_PORTS-1:0]  event_flag;
  logic                   err_flag;
  logic [PSIM_WORD_W-1:0] err_code;
  logic                   warn_seen;
  logic [PSIM_WORD_W-1:0] warn_code;
  logic [PSIM_WORD_W-1:0] pd_mem [PSIM_PORTS][PSIM_AREA_WORDS];
  logic [PSIM_PORTS-1:0]  iol_run;

  logic [PSIM_RX_BITS-1:0] next_rx;
  logic [PSIM_WORD_W-1:0]  next_word;
  logic [PSIM_LEN_W-1:0]   cfg_len_clamped;

  psim_layout u_layout (
    .lay (lay.calc)
  );

  // Two-stage synchroniser for all pin levels
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {i_supply_le_11v, i_supply_le_18v, i_aux_level, i_cq_level,
                 i_supply_trip, i_cq_short};
      sync_b <= sync_a;
    end
  end

  assign short_s = sync_b[PSIM_PORTS-1:0];
  assign trip_s  = sync_b[2*PSIM_PORTS-1:PSIM_PORTS];
  assign cq_s    = sync_b[3*PSIM_PORTS-1:2*PSIM_PORTS];
  assign aux_s   = sync_b[4*PSIM_PORTS-1:3*PSIM_PORTS];
  assign le18_s  = sync_b[4*PSIM_PORTS];
  assign le11_s  = sync_b[4*PSIM_PORTS+1];

  // Lengths beyond one area are limited to the largest area
  assign cfg_len_clamped = (i_cfg_len > PSIM_MAX_BYTES) ? PSIM_MAX_BYTES : i_cfg_len;

  // Port mode, length and validation set by the configuration service
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < PSIM_PORTS; p++) begin
        port_mode[p] <= PSIM_MODE_UNSET;
        port_len[p]  <= PSIM_LEN_RST;
      end
      val_en <= '0;
    end else if (i_cfg_wr) begin
      for (int p = 0; p < PSIM_PORTS; p++) begin
        if (i_cfg_port == 3'(p)) begin
          port_mode[p] <= psim_mode_t'(i_cfg_mode);
          port_len[p]  <= cfg_len_clamped;
          val_en[p]    <= i_cfg_val_en;
        end
      end
    end
  end

  for (genvar p = 0; p < PSIM_PORTS; p++) begin : g_len
    assign lay.byte_len[p] = port_len[p];
    assign iol_run[p]      = (port_mode[p] == PSIM_MODE_IOLINK) && i_iolink_active[p];
  end

  // Supply protection trip holds until the next reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      supply_tripped <= '0;
    end else begin
      supply_tripped <= supply_tripped | trip_s;
    end
  end

  // Event flags: a new event wins over a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_flag <= '0;
    end else begin
      event_flag <= (event_flag & ~(i_event_clear_req | i_event_read))
                    | i_dev_event;
    end
  end

  // Error flag and code are caught once and held
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_flag <= 1'b0;
      err_code <= PSIM_CODE_RST;
    end else if (i_major_fault && !err_flag) begin
      err_flag <= 1'b1;
      err_code <= i_fault_code;
    end
  end

  // Warning code loaded on flag rise, cleared on flag fall
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warn_seen <= 1'b0;
      warn_code <= PSIM_CODE_RST;
    end else begin
      warn_seen <= i_minor_fault;
      if (i_minor_fault && !warn_seen) begin
        warn_code <= i_warn_code;
      end else if (!i_minor_fault) begin
        warn_code <= PSIM_CODE_RST;
      end
    end
  end

  // Process data received from the attached devices
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int p = 0; p < PSIM_PORTS; p++) begin
        for (int w = 0; w < PSIM_AREA_WORDS; w++) begin
          pd_mem[p][w] <= '0;
        end
      end
    end else if (i_pd_wr) begin
      pd_mem[i_pd_port][i_pd_index] <= i_pd_data;
    end
  end

  // Bit input map image
  always_comb begin
    next_rx = '0;
    next_rx[PSIM_RX_WARN]  = i_minor_fault;
    next_rx[PSIM_RX_ERR]   = err_flag;
    next_rx[PSIM_RX_READY] = i_link_up && !err_flag;
    next_rx[PSIM_RX_LE18]  = le18_s;
    next_rx[PSIM_RX_LE11]  = le11_s;
    for (int p = 0; p < PSIM_PORTS; p++) begin
      next_rx[PSIM_RX_EXT + 2*p]     = cq_s[p] && (port_mode[p] == PSIM_MODE_STD_IN);
      next_rx[PSIM_RX_EXT + 2*p + 1] = aux_s[p] && (port_mode[p] != PSIM_MODE_UNSET);
      next_rx[PSIM_RX_CQ_SC + 2*p]   = short_s[p]
                                       && (port_mode[p] == PSIM_MODE_STD_OUT);
      next_rx[PSIM_RX_SUP_SC + p]    = supply_tripped[p];
      next_rx[PSIM_RX_IOL + p]       = iol_run[p];
      next_rx[PSIM_RX_EVENT + p]     = event_flag[p];
      next_rx[PSIM_RX_PD_OK + p]     = iol_run[p] && i_pd_valid[p];
      next_rx[PSIM_RX_VAL_ERR + p]   = iol_run[p] && val_en[p]
                                       && i_id_mismatch[p];
    end
  end

  // Word map read mux; nothing in the map can be written
  always_comb begin
    logic [PSIM_ADDR_W-1:0] rel;
    rel       = '0;
    next_word = '0;
    case (i_word_addr)
      PSIM_ERR_WORD: begin
        next_word = err_code;
      end
      PSIM_WARN_WORD: begin
        next_word = warn_code;
      end
      default: begin
        for (int p = 0; p < PSIM_PORTS; p++) begin
          rel = i_word_addr - lay.start_word[p];
          if ((i_word_addr >= lay.start_word[p])
              && (rel < {3'h0, lay.word_cnt[p]})) begin
            next_word = pd_mem[p][rel[PSIM_IDX_W-1:0]];
          end
        end
      end
    endcase
  end

  // Registered map outputs
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_remote_bit_inputs  <= '0;
      o_remote_word_inputs <= '0;
      o_map_words          <= PSIM_PD_BASE;
    end else begin
      o_remote_bit_inputs  <= next_rx;
      o_remote_word_inputs <= next_word;
      o_map_words          <= lay.map_words;
    end
  end

  // Line enables for the port drivers
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cq_enable  <= '0;
      o_aux_enable <= '0;
      o_supply_en  <= '0;
    end else begin
      for (int p = 0; p < PSIM_PORTS; p++) begin
        o_cq_enable[p]  <= (port_mode[p] != PSIM_MODE_UNSET);
        o_aux_enable[p] <= (port_mode[p] != PSIM_MODE_UNSET);
      end
      o_supply_en <= ~(supply_tripped | trip_s);
    end
  end

endmodule : psim_map

// *** psim_pkg.sv ***
// Constants and types shared by the port status and input map
package psim_pkg;

  localparam int              PSIM_PORTS      = 8;
  localparam int              PSIM_LEN_W      = 6;
  localparam int              PSIM_CNT_W      = 5;
  localparam int              PSIM_ADDR_W     = 8;
  localparam int              PSIM_WORD_W     = 16;
  localparam int              PSIM_IDX_W      = 4;
  localparam int              PSIM_AREA_WORDS = 16;
  localparam int              PSIM_RX_BITS    = 'h70;

  // Largest process data length of one port, in bytes
  localparam logic [5:0]      PSIM_MAX_BYTES  = 6'h20;

  // Word input map offsets
  localparam logic [7:0]      PSIM_ERR_WORD   = 8'h00;
  localparam logic [7:0]      PSIM_WARN_WORD  = 8'h01;
  localparam logic [7:0]      PSIM_PD_BASE    = 8'h04;

  // Bit input map positions
  localparam int              PSIM_RX_WARN    = 'h07;
  localparam int              PSIM_RX_ERR     = 'h0a;
  localparam int              PSIM_RX_READY   = 'h0b;
  localparam int              PSIM_RX_EXT     = 'h10;
  localparam int              PSIM_RX_CQ_SC   = 'h20;
  localparam int              PSIM_RX_SUP_SC  = 'h30;
  localparam int              PSIM_RX_LE18    = 'h38;
  localparam int              PSIM_RX_LE11    = 'h39;
  localparam int              PSIM_RX_IOL     = 'h40;
  localparam int              PSIM_RX_EVENT   = 'h48;
  localparam int              PSIM_RX_PD_OK   = 'h50;
  localparam int              PSIM_RX_VAL_ERR = 'h60;

  // Reset values
  localparam logic [15:0]     PSIM_CODE_RST   = 16'h0000;
  localparam logic [5:0]      PSIM_LEN_RST    = 6'h00;

  typedef enum logic [1:0] {
    PSIM_MODE_UNSET,
    PSIM_MODE_STD_IN,
    PSIM_MODE_STD_OUT,
    PSIM_MODE_IOLINK
  } psim_mode_t;

endpackage : psim_pkg

// *** psim_layout_if.sv ***
// Layout of the per-port process data areas in the word map
interface psim_layout_if;
  import psim_pkg::*;

  logic [PSIM_LEN_W-1:0]  byte_len   [PSIM_PORTS];
  logic [PSIM_ADDR_W-1:0] start_word [PSIM_PORTS];
  logic [PSIM_CNT_W-1:0]  word_cnt   [PSIM_PORTS];
  logic [PSIM_ADDR_W-1:0] map_words;

  modport calc (input byte_len, output start_word, output word_cnt, output map_words);
  modport user (output byte_len, input start_word, input word_cnt, input map_words);

endinterface : psim_layout_if

// *** psim_layout.sv ***
// Start word and size of each port's process data area
module psim_layout
  import psim_pkg::*;
(
  psim_layout_if.calc lay
);

  logic [PSIM_ADDR_W-1:0] chain [PSIM_PORTS+1];

  assign chain[0] = PSIM_PD_BASE;

  for (genvar p = 0; p < PSIM_PORTS; p++) begin : g_area
    logic [PSIM_LEN_W:0] len_up;

    // Half the byte count, odd bytes round up to a whole word
    assign len_up            = {1'b0, lay.byte_len[p]} + 7'h01;
    assign lay.word_cnt[p]   = len_up[PSIM_CNT_W:1];
    // Next port starts right after this one's last word
    assign chain[p+1]        = chain[p] + {3'h0, lay.word_cnt[p]};
    assign lay.start_word[p] = chain[p];
  end

  assign lay.map_words = chain[PSIM_PORTS];

endmodule : psim_layout

// *** psim_map_sva.sv ***
// Checker on the port status and input map ports
module psim_map_sva
  import psim_pkg::*;
(
  input wire logic                    i_mclk,
  input wire logic                    i_rst_b,
  input wire logic                    i_supply_le_18v,
  input wire logic                    i_supply_le_11v,
  input wire logic [PSIM_PORTS-1:0]   i_dev_event,
  input wire logic [PSIM_PORTS-1:0]   i_pd_valid,
  input wire logic [PSIM_ADDR_W-1:0]  i_word_addr,
  input wire logic [PSIM_RX_BITS-1:0] o_remote_bit_inputs,
  input wire logic [PSIM_WORD_W-1:0]  o_remote_word_inputs,
  input wire logic [PSIM_PORTS-1:0]   o_supply_en
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [PSIM_RX_BITS-1:0] b = o_remote_bit_inputs;
  logic      [2:0]              age;

  // Edges since reset release
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence warm;
    age > 3'h3;
  endsequence
  sequence ev_seen(logic [7:0] m);
    (b[PSIM_RX_EVENT+:8] & m) == m;
  endsequence

  low18_a: assert property (warm |-> b[PSIM_RX_LE18] == $past(i_supply_le_18v, 3))
    else $error("Low supply bit wrong");
  deep11_a: assert property (warm |-> b[PSIM_RX_LE11] == $past(i_supply_le_11v, 3))
    else $error("Deep undervoltage bit wrong");
  trip_hold_a: assert property (warm |-> ((o_supply_en & ~$past(o_supply_en)) == 8'h00)
    && (($past(b[PSIM_RX_SUP_SC+:8]) & ~b[PSIM_RX_SUP_SC+:8]) == 8'h00))
    else $error("Supply trip not held");
  odd_short_a: assert property ((b[PSIM_RX_CQ_SC+:16] & 16'haaaa) == 16'h0000)
    else $error("Odd short bit set");
  err_ready_a: assert property (b[PSIM_RX_ERR] |-> !b[PSIM_RX_READY])
    else $error("Ready with error flag");
  err_stick_a: assert property (warm and $past(b[PSIM_RX_ERR]) |-> b[PSIM_RX_ERR])
    else $error("Error flag dropped");
  event_set_a: assert property (i_dev_event != 8'h00 |-> ##2 ev_seen($past(i_dev_event, 2)))
    else $error("Event bit not set");
  pd_ok_a: assert property (warm |->
    (b[PSIM_RX_PD_OK+:8] & ~($past(i_pd_valid) & b[PSIM_RX_IOL+:8])) == 8'h00)
    else $error("Valid bit without cause");
  warn_zero_a: assert property (!b[PSIM_RX_WARN] && $past(!b[PSIM_RX_WARN])
    && $past(i_word_addr) == PSIM_WARN_WORD |-> o_remote_word_inputs == 16'h0000)
    else $error("Warning code not cleared");
  err_hold_a: assert property (warm and $past(b[PSIM_RX_ERR], 2) && i_word_addr == PSIM_ERR_WORD
    && $past(i_word_addr) == PSIM_ERR_WORD |=> $stable(o_remote_word_inputs))
    else $error("Error code changed");
endmodule : psim_map_sva

bind psim_map psim_map_sva psim_map_sva_i (.*);

// *** psim_master_model.sv ***
// Model of the master station reading the word map
module psim_master_model
  import psim_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic [PSIM_WORD_W-1:0] i_word,
  output logic      [PSIM_ADDR_W-1:0] o_word_addr,
  output logic      [PSIM_PORTS-1:0]  o_clear_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_word_addr = 8'h00;
    o_clear_req = 8'h00;
  end
  // Reads any word address it is given, sampled at the falling edge after two rising edges past the address
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_mclk) o_word_addr = a;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) d = i_word;
  endtask : read
  // Holds the clear request for three cycles
  task automatic clear(input logic [7:0] m);
    @(negedge i_mclk) o_clear_req = m;
    repeat (3) @(negedge i_mclk);
    o_clear_req = 8'h00;
  endtask : clear
endmodule : psim_master_model

// *** tb.sv ***
// Self-checking bench for the port status and input map
module tb
  import psim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_rst_b, i_cfg_wr, i_cfg_val_en, i_supply_le_18v, i_supply_le_11v;
  logic i_pd_wr, i_link_up, i_major_fault, i_minor_fault;
  logic [2:0] i_cfg_port, i_pd_port;
  logic [1:0] i_cfg_mode;
  logic [5:0] i_cfg_len;
  logic [3:0] i_pd_index;
  logic [7:0] i_cq_short, i_supply_trip, i_cq_level, i_aux_level, i_iolink_active;
  logic [7:0] i_dev_event, i_event_read, i_pd_valid, i_id_mismatch, i_event_clear_req;
  logic [7:0] i_word_addr, o_map_words, o_cq_enable, o_aux_enable, o_supply_en, st;
  logic [15:0] i_pd_data, i_fault_code, i_warn_code, o_remote_word_inputs, rd;
  logic [111:0] o_remote_bit_inputs;
  logic [5:0] ln [8] = '{6'h05, 6'h02, 6'h00, 6'h28, 6'h01, 6'h04, 6'h00, 6'h20};
  int failures, n_compared;

  psim_map psim_map_i (.*);
  psim_master_model m_i (.i_mclk(i_mclk), .i_word(o_remote_word_inputs),
    .o_word_addr(i_word_addr), .o_clear_req(i_event_clear_req));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic cb(input int o, input logic [7:0] e);
    chk({8'h00, o_remote_bit_inputs[o+:8]}, {8'h00, e});
  endtask : cb
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  task automatic cfg(input logic [2:0] p, input logic [1:0] m, input logic [5:0] l,
                     input logic v);
    @(negedge i_mclk) {i_cfg_wr, i_cfg_port, i_cfg_mode, i_cfg_len, i_cfg_val_en} = {1'b1, p, m, l, v};
    @(negedge i_mclk) i_cfg_wr = 1'b0;
  endtask : cfg
  task automatic pdw(input logic [2:0] p, input logic [3:0] x, input logic [15:0] d);
    @(negedge i_mclk) {i_pd_wr, i_pd_port, i_pd_index, i_pd_data} = {1'b1, p, x, d};
    @(negedge i_mclk) i_pd_wr = 1'b0;
  endtask : pdw

  task automatic t_layout;
    logic [4:0] w;
    st = PSIM_PD_BASE;
    for (int p = 0; p < 8; p++) cfg(3'(p), 2'(16'hcdfb >> 2 * p), ln[p], 1'(8'h89 >> p));
    cyc(2);
    chk({8'h00, o_cq_enable}, 16'h00bf);
    chk({8'h00, o_aux_enable}, 16'h00bf);
    chk(o_remote_bit_inputs[PSIM_RX_EXT+:16], 16'h8922);
    for (int p = 0; p < 8; p++) begin
      w = 5'((((ln[p] > 6'h20) ? 6'h20 : ln[p]) + 6'h01) >> 1);
      if (w != 5'h00) begin
        pdw(3'(p), 4'(w - 5'h01), {8'hd0, 8'(p)});
        pdw(3'(p), 4'h0, {8'ha0, 8'(p)});
        m_i.read(st, rd);
        chk(rd, {8'ha0, 8'(p)});
        m_i.read(st + 8'(w) - 8'h01, rd);
        chk(rd, {(w == 5'h01) ? 8'ha0 : 8'hd0, 8'(p)});
      end
      st = st + 8'(w);
    end
    chk({8'h00, o_map_words}, {8'h00, st});
  endtask : t_layout

  task automatic t_pins;
    @(negedge i_mclk) {i_cq_short, i_supply_trip, i_supply_le_18v} = {8'h03, 8'h08, 1'b1};
    cyc(5);
    cb(PSIM_RX_CQ_SC, 8'h04);
    cb(PSIM_RX_SUP_SC, 8'h08);
    cb(PSIM_RX_LE18, 8'h01);
    chk({8'h00, o_supply_en}, 16'h00f7);
    @(negedge i_mclk) {i_cq_short, i_supply_trip, i_supply_le_11v} = {8'h00, 8'h00, 1'b1};
    cyc(5);
    cb(PSIM_RX_CQ_SC, 8'h00);
    cb(PSIM_RX_SUP_SC, 8'h08);
    cb(PSIM_RX_LE18, 8'h03);
    @(negedge i_mclk) {i_supply_le_18v, i_supply_le_11v} = 2'h0;
    cyc(5);
    cb(PSIM_RX_LE18, 8'h00);
  endtask : t_pins

  task automatic t_iolink;
    @(negedge i_mclk) {i_iolink_active, i_pd_valid, i_id_mismatch} = {8'hff, 8'h7f, 8'hff};
    cyc(3);
    cb(PSIM_RX_IOL, 8'had);
    cb(PSIM_RX_PD_OK, 8'h2d);
    cb(PSIM_RX_VAL_ERR, 8'h89);
    @(negedge i_mclk) {i_iolink_active, i_id_mismatch} = {8'h7f, 8'h08};
    cyc(3);
    cb(PSIM_RX_VAL_ERR, 8'h08);
    cfg(3'h3, 2'h3, 6'h28, 1'b0);
    cyc(3);
    cb(PSIM_RX_VAL_ERR, 8'h00);
  endtask : t_iolink

  task automatic t_event;
    @(negedge i_mclk) i_dev_event = 8'h06;
    @(negedge i_mclk) i_dev_event = 8'h00;
    cyc(2);
    cb(PSIM_RX_EVENT, 8'h06);
    m_i.clear(8'h04);
    @(negedge i_mclk) i_event_read = 8'h02;
    @(negedge i_mclk) i_event_read = 8'h00;
    cyc(3);
    cb(PSIM_RX_EVENT, 8'h00);
  endtask : t_event

  task automatic t_fault;
    @(negedge i_mclk) {i_minor_fault, i_warn_code} = {1'b1, 16'h1234};
    @(negedge i_mclk) i_warn_code = 16'h5555;
    m_i.read(PSIM_WARN_WORD, rd);
    chk(rd, 16'h1234);
    cb(PSIM_RX_WARN, 8'h11);
    @(negedge i_mclk) i_minor_fault = 1'b0;
    m_i.read(PSIM_WARN_WORD, rd);
    chk(rd, 16'h0000);
    @(negedge i_mclk) {i_major_fault, i_fault_code} = {1'b1, 16'hbeef};
    @(negedge i_mclk) {i_major_fault, i_fault_code} = {1'b0, 16'h0bad};
    cyc(2);
    cb(PSIM_RX_WARN, 8'h08);
    @(negedge i_mclk) i_major_fault = 1'b1;
    m_i.read(PSIM_ERR_WORD, rd);
    chk(rd, 16'hbeef);
  endtask : t_fault

  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    {i_rst_b, i_cfg_wr, i_cfg_val_en, i_supply_le_18v, i_supply_le_11v} = 5'h00;
    {i_pd_wr, i_major_fault, i_minor_fault, i_link_up} = 4'h1;
    {i_cfg_port, i_pd_port, i_cfg_mode, i_cfg_len, i_pd_index} = 18'h00000;
    {i_cq_short, i_supply_trip, i_iolink_active, i_dev_event, i_event_read} = 40'h0;
    {i_pd_valid, i_id_mismatch, i_cq_level, i_aux_level} = 32'h00005aa5;
    {i_pd_data, i_fault_code, i_warn_code} = 48'h0;
    failures = 0;
    n_compared = 0;
    cyc(6);
    i_rst_b = 1'b1;
    t_layout;
    t_pins;
    t_iolink;
    t_event;
    t_fault;
    print_verdict;
  end
endmodule : tb
